// ===== design/bstc_top.sv
// baseband symbol path control: settings, trigger, delay, encoding, symbol assembly
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// RULE1: encoded bit is one when bits differ
// RULE2: encoder enable setting, off after reset
// RULE3: polarity one inverts Q, normal after reset
// RULE4: baseband enable setting, off after reset
// RULE5: trigger source key, bus, external; key default
// RULE6: external delay zero to 1048575 bit periods
// RULE7: delay only with switch on and external
// RULE8: external trigger high or low active
// RULE9: sampling clock internal or external, internal default
// RULE10: bits per symbol follow modulation type; 32QAM and wider are held at 4
// RULE11: symbol rate range checked, reset 24.3 ksps
// RULE12: modulation type selector, QPSK after reset
// RULE13: MSK bias 0..90, applies only for MSK
// RULE14: delay down-counter ticks once per bit
module bstc_top
	import bstc_pkg::*;
#(
	parameter int DELAY_W    = BSTC_DELAY_W,
	parameter int FIFO_DEPTH = BSTC_FIFO_DEPTH
) (
	input  wire logic                   i_clock,
	input  wire logic                   i_rst_b,
	// settings from the command interpreter
	input  wire logic                   i_cfg_write,
	input  wire logic                   i_baseband_enable,
	input  wire bstc_pkg::bstc_mod_e    i_mod_type,
	input  wire logic [31:0]            i_symbol_rate,
	input  wire logic [6:0]             i_msk_bias,
	input  wire logic                   i_diff_encode_enable,
	input  wire logic                   i_phase_polarity,
	input  wire logic                   i_sample_clock_select,
	input  wire bstc_pkg::bstc_trig_src_e i_trig_source,
	input  wire logic                   i_ext_trigger_polarity,
	input  wire logic                   i_ext_delay_enable,
	input  wire logic [DELAY_W-1:0]     i_ext_delay,
	// trigger events
	input  wire logic                   i_key_trigger,
	input  wire logic                   i_bus_trigger,
	input  wire logic                   i_ext_trigger,
	// bit stream in, one bit per bit-period tick
	input  wire logic                   i_bit_tick,
	input  wire logic                   i_data_bit,
	// symbols out to the modulator
	output logic                        o_sym_valid,
	input  wire logic                   i_sym_ready,
	output logic [3:0]                  o_sym_data,
	// status and steering toward the modulator
	output logic                        o_baseband_on,
	output logic                        o_running,
	output logic                        o_delaying,
	output logic [2:0]                  o_bits_per_symbol,
	output logic                        o_q_invert,
	output logic                        o_sample_clock_select,
	output logic [31:0]                 o_symbol_rate,
	output logic [6:0]                  o_msk_bias,
	output logic                        o_msk_bias_active,
	output logic                        o_cfg_error,
	output logic                        o_overflow
);
	import bstc_pkg::*;

	// ----------------------------------------
	// settings
	// ----------------------------------------
	logic                bb_en_reg;
	bstc_mod_e           mod_reg;
	logic [31:0]         rate_reg;
	logic [6:0]          bias_reg;
	logic                denc_reg;
	logic                pol_reg;
	logic                clk_sel_reg;
	bstc_trig_src_e      src_reg;
	logic                ext_trigger_polarity_reg;
	logic                dly_en_reg;
	logic [DELAY_W-1:0]  dly_reg;
	logic                cfg_err_reg;

	wire rate_ok;
	wire bias_ok;
	wire src_ok;
	wire cfg_ok;

	// out-of-range values are refused whole so settings stay consistent
	assign rate_ok = (i_symbol_rate >= BSTC_RATE_MIN) && (i_symbol_rate <= BSTC_RATE_MAX); // RULE11
	assign bias_ok = (i_msk_bias <= BSTC_BIAS_MAX); // RULE13
	assign src_ok  = (i_trig_source != 2'h3); // RULE5
	assign cfg_ok  = rate_ok && bias_ok && src_ok;

	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			bb_en_reg   <= 1'b0;              // RULE4
			mod_reg     <= BSTC_MOD_RST;      // RULE12
			rate_reg    <= BSTC_RATE_RST;     // RULE11
			bias_reg    <= BSTC_BIAS_RST;     // RULE13
			denc_reg    <= 1'b0;              // RULE2
			pol_reg     <= BSTC_POL_NORMAL;   // RULE3
			clk_sel_reg <= BSTC_CLK_INTERNAL; // RULE9
			src_reg     <= BSTC_SRC_RST;      // RULE5
			ext_trigger_polarity_reg   <= BSTC_EXT_TRIGGER_POLARITY_HIGH;   // RULE8
			dly_en_reg  <= 1'b0;              // RULE7
			dly_reg     <= DELAY_W'(BSTC_DELAY_RST); // RULE6
			cfg_err_reg <= 1'b0;
		end
		else if (i_cfg_write)
		begin
			cfg_err_reg <= !cfg_ok;
			if (cfg_ok)
			begin
				bb_en_reg   <= i_baseband_enable;     // RULE4
				mod_reg     <= i_mod_type;            // RULE12
				rate_reg    <= i_symbol_rate;         // RULE11
				bias_reg    <= i_msk_bias;            // RULE13
				denc_reg    <= i_diff_encode_enable;  // RULE2
				pol_reg     <= i_phase_polarity;      // RULE3
				clk_sel_reg <= i_sample_clock_select; // RULE9
				src_reg     <= i_trig_source;         // RULE5
				ext_trigger_polarity_reg   <= i_ext_trigger_polarity; // RULE8
				dly_en_reg  <= i_ext_delay_enable;    // RULE7
				dly_reg     <= i_ext_delay;           // RULE6
			end
		end
	end

	// ----------------------------------------
	// bits per symbol
	// ----------------------------------------
	logic [2:0] bps;

	always_comb
	begin
		unique case (mod_reg) // RULE10
			BSTC_MOD_BPSK, BSTC_MOD_MSK, BSTC_MOD_2FSK, BSTC_MOD_ASK:
				bps = 3'h1;
			BSTC_MOD_QPSK, BSTC_MOD_IS95QPSK, BSTC_MOD_GRAYQPSK, BSTC_MOD_OQPSK,
			BSTC_MOD_IS95OQPSK, BSTC_MOD_P4DQPSK, BSTC_MOD_4FSK, BSTC_MOD_4QAM,
			BSTC_MOD_C4FM:
				bps = 3'h2;
			BSTC_MOD_8PSK, BSTC_MOD_D8PSK, BSTC_MOD_8FSK:
				bps = 3'h3;
			BSTC_MOD_16PSK, BSTC_MOD_16FSK, BSTC_MOD_16QAM:
				bps = 3'h4;
			// wider constellations need more lanes than this path carries
			default:
				bps = 3'h4;
		endcase
	end

	// ----------------------------------------
	// trigger selection
	// ----------------------------------------
	wire ext_active;
	wire trig_hit;
	wire use_delay;

	assign ext_active = (ext_trigger_polarity_reg == BSTC_EXT_TRIGGER_POLARITY_LOW) ? !i_ext_trigger : i_ext_trigger; // RULE8
	assign trig_hit   = (src_reg == BSTC_TRIG_KEY && i_key_trigger)
	                 || (src_reg == BSTC_TRIG_BUS && i_bus_trigger)
	                 || (src_reg == BSTC_TRIG_EXT && ext_active); // RULE5
	assign use_delay  = dly_en_reg && (src_reg == BSTC_TRIG_EXT)
	                 && (dly_reg != '0); // RULE7

	// ----------------------------------------
	// trigger state machine and delay counter
	// ----------------------------------------
	bstc_state_e        state_reg;
	bstc_state_e        state_next;
	logic [DELAY_W-1:0] dcnt_reg;
	logic [DELAY_W-1:0] dcnt_next;

	always_comb
	begin
		state_next = state_reg;
		dcnt_next  = dcnt_reg;
		unique case (state_reg)
			BSTC_ST_IDLE:
				if (bb_en_reg && trig_hit)
				begin
					if (use_delay)
					begin
						state_next = BSTC_ST_DELAY;
						dcnt_next  = dly_reg; // RULE14
					end
					else
						state_next = BSTC_ST_RUN;
				end
			BSTC_ST_DELAY:
				if (i_bit_tick)
				begin
					dcnt_next = dcnt_reg - 1'b1; // RULE14
					if (dcnt_reg == DELAY_W'(1))
						state_next = BSTC_ST_RUN; // RULE6
				end
			BSTC_ST_RUN:
				state_next = BSTC_ST_RUN;
			default:
				state_next = BSTC_ST_IDLE;
		endcase
		// switching baseband off ends any output
		if (!bb_en_reg)
			state_next = BSTC_ST_IDLE; // RULE4
	end

	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			state_reg <= BSTC_ST_IDLE;
			dcnt_reg  <= '0;
		end
		else
		begin
			state_reg <= state_next;
			dcnt_reg  <= dcnt_next;
		end
	end

	// ----------------------------------------
	// encoding and symbol assembly
	// ----------------------------------------
	wire       running;
	wire       take_bit;
	wire       enc_bit;
	logic [3:0] shift_reg;
	logic [2:0] nbits_reg;
	wire       sym_done;
	wire [3:0] shift_next;

	assign running    = (state_reg == BSTC_ST_RUN);
	assign take_bit   = running && i_bit_tick;
	assign shift_next = {shift_reg[2:0], enc_bit};
	assign sym_done   = take_bit && (nbits_reg + 3'h1 == bps); // RULE10

	bstc_diff_enc u_enc (
		.i_clock     (i_clock),
		.i_rst_b     (i_rst_b),
		.i_enable    (denc_reg),
		.i_clear     (!running),
		.i_bit_valid (take_bit),
		.i_bit       (i_data_bit),
		.o_bit       (enc_bit)
	); // RULE1 RULE2

	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			shift_reg <= 4'h0;
			nbits_reg <= 3'h0;
		end
		else if (!running)
		begin
			shift_reg <= 4'h0;
			nbits_reg <= 3'h0;
		end
		else if (take_bit)
		begin
			shift_reg <= sym_done ? 4'h0 : shift_next;
			nbits_reg <= sym_done ? 3'h0 : nbits_reg + 3'h1;
		end
	end

	// ----------------------------------------
	// symbol FIFO toward the modulator
	// ----------------------------------------
	wire       fifo_in_ready;
	wire       fifo_out_valid;
	wire [3:0] fifo_out_data;
	wire       fifo_pop;
	logic      ovf_reg;

	bstc_fifo #(
		.WIDTH (4),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clock     (i_clock),
		.i_rst_b     (i_rst_b),
		.i_in_valid  (sym_done),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   (shift_next),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (fifo_pop),
		.o_out_data  (fifo_out_data),
		.i_flush     (!running)
	);

	// output stage register; pops only when it is empty or being drained
	assign fifo_pop = fifo_out_valid && (!o_sym_valid || i_sym_ready);

	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_sym_valid <= 1'b0;
			o_sym_data  <= 4'h0;
		end
		else if (!running)
		begin
			o_sym_valid <= 1'b0;
			o_sym_data  <= 4'h0;
		end
		else if (fifo_pop)
		begin
			o_sym_valid <= 1'b1;
			o_sym_data  <= fifo_out_data;
		end
		else if (i_sym_ready)
			o_sym_valid <= 1'b0;
	end

	// bit source cannot be paused, so a full FIFO loses the symbol and flags it
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
			ovf_reg <= 1'b0;
		else if (sym_done && !fifo_in_ready)
			ovf_reg <= 1'b1;
		else if (i_cfg_write)
			ovf_reg <= 1'b0;
	end

	// ----------------------------------------
	// registered status outputs
	// ----------------------------------------
	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			o_baseband_on         <= 1'b0;
			o_running             <= 1'b0;
			o_delaying            <= 1'b0;
			o_bits_per_symbol     <= 3'h2;
			o_q_invert            <= 1'b0;
			o_sample_clock_select <= BSTC_CLK_INTERNAL;
			o_symbol_rate         <= BSTC_RATE_RST;
			o_msk_bias            <= BSTC_BIAS_RST;
			o_msk_bias_active     <= 1'b0;
			o_cfg_error           <= 1'b0;
			o_overflow            <= 1'b0;
		end
		else
		begin
			o_baseband_on         <= bb_en_reg;
			o_running             <= running;
			o_delaying            <= (state_reg == BSTC_ST_DELAY);
			o_bits_per_symbol     <= bps;
			o_q_invert            <= (pol_reg == BSTC_POL_INVERT); // RULE3
			o_sample_clock_select <= clk_sel_reg; // RULE9
			o_symbol_rate         <= rate_reg;
			o_msk_bias            <= bias_reg;
			o_msk_bias_active     <= (mod_reg == BSTC_MOD_MSK); // RULE13
			o_cfg_error           <= cfg_err_reg;
			o_overflow            <= ovf_reg;
		end
	end
endmodule
`default_nettype wire

// ===== design/bstc_pkg.sv
// package of constants, enumerations and reset values for the baseband symbol trigger control
package bstc_pkg;
	// ----------------------------------------
	// modulation types
	// ----------------------------------------
	typedef enum logic [4:0]
	{
		BSTC_MOD_BPSK     = 5'h00,
		BSTC_MOD_QPSK     = 5'h01,
		BSTC_MOD_IS95QPSK = 5'h02,
		BSTC_MOD_GRAYQPSK = 5'h03,
		BSTC_MOD_OQPSK    = 5'h04,
		BSTC_MOD_IS95OQPSK = 5'h05,
		BSTC_MOD_P4DQPSK  = 5'h06,
		BSTC_MOD_8PSK     = 5'h07,
		BSTC_MOD_16PSK    = 5'h08,
		BSTC_MOD_D8PSK    = 5'h09,
		BSTC_MOD_MSK      = 5'h0A,
		BSTC_MOD_2FSK     = 5'h0B,
		BSTC_MOD_4FSK     = 5'h0C,
		BSTC_MOD_8FSK     = 5'h0D,
		BSTC_MOD_16FSK    = 5'h0E,
		BSTC_MOD_C4FM     = 5'h0F,
		BSTC_MOD_4QAM     = 5'h10,
		BSTC_MOD_16QAM    = 5'h11,
		BSTC_MOD_32QAM    = 5'h12,
		BSTC_MOD_64QAM    = 5'h13,
		BSTC_MOD_128QAM   = 5'h14,
		BSTC_MOD_256QAM   = 5'h15,
		BSTC_MOD_512QAM   = 5'h16,
		BSTC_MOD_1024QAM  = 5'h17,
		BSTC_MOD_ASK      = 5'h18
	} bstc_mod_e;

	// ----------------------------------------
	// trigger sources and state
	// ----------------------------------------
	typedef enum logic [1:0]
	{
		BSTC_TRIG_KEY = 2'h0,
		BSTC_TRIG_BUS = 2'h1,
		BSTC_TRIG_EXT = 2'h2
	} bstc_trig_src_e;

	typedef enum logic [1:0]
	{
		BSTC_ST_IDLE  = 2'h0,
		BSTC_ST_DELAY = 2'h1,
		BSTC_ST_RUN   = 2'h2
	} bstc_state_e;

	// ----------------------------------------
	// widths and reset values
	// ----------------------------------------
	localparam int         BSTC_DELAY_W        = 20;
	localparam int         BSTC_RATE_W         = 32;
	localparam int         BSTC_BIAS_W         = 7;
	localparam logic [19:0] BSTC_DELAY_MAX     = 20'hFFFFF;
	localparam logic [19:0] BSTC_DELAY_RST     = 20'h00000;
	// symbol rate in whole symbols per second, so 50 sps .. 50 Msps fits 32 bits
	localparam logic [31:0] BSTC_RATE_MIN      = 32'h00000032;
	localparam logic [31:0] BSTC_RATE_MAX      = 32'h02FAF080;
	localparam logic [31:0] BSTC_RATE_RST      = 32'h00005EEC;
	localparam logic [6:0]  BSTC_BIAS_MAX      = 7'h5A;
	localparam logic [6:0]  BSTC_BIAS_RST      = 7'h5A;
	localparam logic        BSTC_POL_NORMAL    = 1'b0;
	localparam logic        BSTC_POL_INVERT    = 1'b1;
	localparam logic        BSTC_EXT_TRIGGER_POLARITY_HIGH    = 1'b0;
	localparam logic        BSTC_EXT_TRIGGER_POLARITY_LOW     = 1'b1;
	localparam logic        BSTC_CLK_INTERNAL  = 1'b0;
	localparam bstc_mod_e   BSTC_MOD_RST       = BSTC_MOD_QPSK;
	localparam bstc_trig_src_e BSTC_SRC_RST    = BSTC_TRIG_KEY;
	localparam int          BSTC_FIFO_DEPTH    = 4;
endpackage

// ===== design/bstc_fifo.sv
// small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module bstc_fifo #(
	parameter int WIDTH = 1,
	parameter int DEPTH = 4
) (
	input  wire logic             i_clock,
	input  wire logic             i_rst_b,
	input  wire logic             i_in_valid,
	output logic                  o_in_ready,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_out_valid,
	input  wire logic             i_out_ready,
	output logic      [WIDTH-1:0] o_out_data,
	input  wire logic             i_flush
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	wire              do_push;
	wire              do_pop;

	assign o_in_ready  = (count_reg != (AW+1)'(DEPTH)) && !i_flush;
	assign o_out_valid = (count_reg != '0);
	assign o_out_data  = mem_reg[rd_ptr_reg];
	assign do_push     = i_in_valid && o_in_ready;
	assign do_pop      = o_out_valid && i_out_ready;

	always_ff @(posedge i_clock)
	begin
		if (do_push)
			mem_reg[wr_ptr_reg] <= i_in_data;
	end

	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else if (i_flush)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end
		else
		begin
			if (do_push)
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
			if (do_pop)
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
			count_reg <= count_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
		end
	end
endmodule
`default_nettype wire

// ===== design/bstc_diff_enc.sv
// differential encoder for the serial data bit stream
`timescale 1ns/1ns
`default_nettype none
module bstc_diff_enc (
	input  wire logic i_clock,
	input  wire logic i_rst_b,
	input  wire logic i_enable,
	input  wire logic i_clear,
	input  wire logic i_bit_valid,
	input  wire logic i_bit,
	output logic      o_bit
);
	logic prev_bit_reg;

	// history starts at zero so the first bit passes as itself
	assign o_bit = i_enable ? (i_bit ^ prev_bit_reg) : i_bit; // RULE1

	always_ff @(posedge i_clock or negedge i_rst_b)
	begin
		if (!i_rst_b)
			prev_bit_reg <= 1'b0;
		else if (i_clear)
			prev_bit_reg <= 1'b0;
		else if (i_bit_valid)
			prev_bit_reg <= i_bit;
	end
endmodule
`default_nettype wire

// ===== bench/bstc_checker.sv
// concurrent checks on the ports of the symbol trigger control
`timescale 1ns/1ns
`default_nettype none
module bstc_checker
	import bstc_pkg::*;
#(
	parameter int DELAY_W = BSTC_DELAY_W
) (
	input  wire logic                     i_clock,
	input  wire logic                     i_rst_b,
	input  wire logic                     i_cfg_write,
	input  wire bstc_pkg::bstc_mod_e      i_mod_type,
	input  wire logic [31:0]              i_symbol_rate,
	input  wire logic [6:0]               i_msk_bias,
	input  wire logic                     i_phase_polarity,
	input  wire logic                     i_sample_clock_select,
	input  wire bstc_pkg::bstc_trig_src_e i_trig_source,
	input  wire logic                     i_ext_delay_enable,
	input  wire logic [DELAY_W-1:0]       i_ext_delay,
	input  wire logic                     i_bit_tick,
	input  wire logic                     o_delaying,
	input  wire logic [2:0]               o_bits_per_symbol,
	input  wire logic                     o_q_invert,
	input  wire logic                     o_sample_clock_select,
	input  wire logic [31:0]              o_symbol_rate,
	input  wire logic [6:0]               o_msk_bias,
	input  wire logic                     o_msk_bias_active,
	input  wire logic                     o_cfg_error
);
	// ----------------------------------------
	// expected settings and delay tick count
	// ----------------------------------------
	wire logic       ok_w = i_symbol_rate >= BSTC_RATE_MIN && i_symbol_rate <= BSTC_RATE_MAX
		&& i_msk_bias <= BSTC_BIAS_MAX && i_trig_source != 2'h3;
	wire logic [2:0] bps_w = (i_mod_type == BSTC_MOD_BPSK || i_mod_type == BSTC_MOD_MSK
		|| i_mod_type == BSTC_MOD_2FSK) ? 3'h1
		: (i_mod_type == BSTC_MOD_QPSK || i_mod_type == BSTC_MOD_OQPSK) ? 3'h2
		: i_mod_type == BSTC_MOD_8FSK ? 3'h3 : i_mod_type == BSTC_MOD_16QAM ? 3'h4 : 3'h0;
	logic [1:0]         src_reg;
	logic               den_reg;
	logic [DELAY_W-1:0] dly_reg;
	logic [DELAY_W-1:0] cnt_reg;
	logic               tick_reg;
	always_ff @(posedge i_clock or negedge i_rst_b)
		if (!i_rst_b)
			{src_reg, den_reg, dly_reg} <= '0;
		else if (i_cfg_write && ok_w)
			{src_reg, den_reg, dly_reg} <= {i_trig_source, i_ext_delay_enable, i_ext_delay};
	// tick delayed one cycle, since o_delaying lags the state by one cycle
	always_ff @(posedge i_clock or negedge i_rst_b)
		if (!i_rst_b)
			{tick_reg, cnt_reg} <= '0;
		else
			{tick_reg, cnt_reg} <= {i_bit_tick, o_delaying ? cnt_reg + DELAY_W'(tick_reg) : '0};
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	rst_vals_a: assert property ($rose(i_rst_b) |-> o_symbol_rate == BSTC_RATE_RST
		&& o_msk_bias == BSTC_BIAS_RST && o_bits_per_symbol == 3'h2 && !o_q_invert)
		else $error("reset values wrong");
	q_invert_a: assert property (i_cfg_write && ok_w |-> ##2 o_q_invert == $past(i_phase_polarity, 2))
		else $error("q invert not taken");
	clock_sel_a: assert property (i_cfg_write && ok_w
		|-> ##2 o_sample_clock_select == $past(i_sample_clock_select, 2)) else $error("clock select");
	bits_map_a: assert property (i_cfg_write && ok_w && bps_w != 3'h0 |-> ##2
		o_bits_per_symbol == $past(bps_w, 2)) else $error("bits per symbol wrong");
	cfg_refuse_a: assert property (i_cfg_write && !ok_w && !$past(i_cfg_write) |-> ##2
		o_cfg_error && o_symbol_rate == $past(o_symbol_rate, 2)) else $error("bad write stored");
	bias_take_a: assert property (i_cfg_write && ok_w |-> ##2 o_msk_bias == $past(i_msk_bias, 2))
		else $error("bias not taken");
	msk_active_a: assert property (i_cfg_write && ok_w |-> ##2
		o_msk_bias_active == ($past(i_mod_type, 2) == BSTC_MOD_MSK)) else $error("bias active");
	delay_gate_a: assert property (o_delaying |-> src_reg == BSTC_TRIG_EXT && den_reg
		&& dly_reg != '0) else $error("delay without ext source and switch");
	delay_count_a: assert property ($fell(o_delaying) |-> cnt_reg == dly_reg)
		else $error("delay tick count wrong");
endmodule
`default_nettype wire

// ===== bench/bstc_far_model.sv
// far side model: serial bit source and symbol sink
`timescale 1ns/1ns
`default_nettype none
module bstc_far_model (
	input  wire logic        i_clock,
	input  wire logic        i_rst_b,
	input  wire logic        i_hold,
	input  wire logic        i_stall,
	input  wire logic [15:0] i_pattern,
	output logic             o_bit_tick,
	output logic             o_data_bit,
	output logic             o_sym_ready
);
	// ----------------------------------------
	// one bit every eight cycles, msb first
	// ----------------------------------------
	logic [2:0] div_reg;
	logic [3:0] idx_reg;
	wire logic  bit_w = i_pattern[4'hF - idx_reg];
	assign o_bit_tick  = !i_hold && div_reg == 3'h7;
	// off the tick the line shows the inverse, so a stale sample shows up
	assign o_data_bit  = o_bit_tick ? bit_w : !bit_w;
	assign o_sym_ready = !i_stall;
	always_ff @(posedge i_clock or negedge i_rst_b)
		if (!i_rst_b)
			{div_reg, idx_reg} <= '0;
		else if (i_hold)
			{div_reg, idx_reg} <= '0;
		else
			{div_reg, idx_reg} <= {div_reg + 3'h1, idx_reg + 4'(o_bit_tick)};
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
// testbench top for the symbol trigger control
`timescale 1ns/1ns
`default_nettype none
bind bstc_top bstc_checker #(.DELAY_W(DELAY_W)) u_chk (.i_clock, .i_rst_b, .i_cfg_write,
	.i_mod_type, .i_symbol_rate, .i_msk_bias, .i_phase_polarity, .i_sample_clock_select,
	.i_trig_source, .i_ext_delay_enable, .i_ext_delay, .i_bit_tick, .o_delaying,
	.o_bits_per_symbol, .o_q_invert, .o_sample_clock_select, .o_symbol_rate, .o_msk_bias,
	.o_msk_bias_active, .o_cfg_error);
module tb_top;
	import bstc_pkg::*;
	logic           i_clock, i_rst_b, i_cfg_write, i_baseband_enable, i_diff_encode_enable;
	logic           i_phase_polarity, i_sample_clock_select, i_ext_trigger_polarity;
	logic           i_ext_delay_enable, i_key_trigger, i_bus_trigger, i_ext_trigger, hold, stall;
	logic           i_bit_tick, i_data_bit, i_sym_ready, o_sym_valid, o_baseband_on, o_running;
	logic           o_delaying, o_q_invert, o_sample_clock_select, o_msk_bias_active;
	logic           o_cfg_error, o_overflow;
	logic [2:0]     o_bits_per_symbol;
	logic [3:0]     o_sym_data;
	logic [6:0]     i_msk_bias, o_msk_bias;
	logic [15:0]    pattern;
	logic [19:0]    i_ext_delay;
	logic [31:0]    i_symbol_rate, o_symbol_rate;
	bstc_mod_e      i_mod_type;
	bstc_trig_src_e i_trig_source;
	logic [3:0]     got [$];
	int             failures = 0;
	int             checked = 0;
	bstc_mod_e      mods [7] = '{BSTC_MOD_BPSK, BSTC_MOD_MSK, BSTC_MOD_2FSK, BSTC_MOD_OQPSK,
		BSTC_MOD_QPSK, BSTC_MOD_8FSK, BSTC_MOD_16QAM};
	logic [2:0]     bps [7] = '{3'h1, 3'h1, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4};
	bstc_top dut (.i_clock, .i_rst_b, .i_cfg_write, .i_baseband_enable, .i_mod_type,
		.i_symbol_rate, .i_msk_bias, .i_diff_encode_enable, .i_phase_polarity,
		.i_sample_clock_select, .i_trig_source, .i_ext_trigger_polarity, .i_ext_delay_enable,
		.i_ext_delay, .i_key_trigger, .i_bus_trigger, .i_ext_trigger, .i_bit_tick, .i_data_bit,
		.o_sym_valid, .i_sym_ready, .o_sym_data, .o_baseband_on, .o_running, .o_delaying,
		.o_bits_per_symbol, .o_q_invert, .o_sample_clock_select, .o_symbol_rate, .o_msk_bias,
		.o_msk_bias_active, .o_cfg_error, .o_overflow);
	bstc_far_model far (.i_clock, .i_rst_b, .i_hold(hold), .i_stall(stall), .i_pattern(pattern),
		.o_bit_tick(i_bit_tick), .o_data_bit(i_data_bit), .o_sym_ready(i_sym_ready));
	// ----------------------------------------
	// clock, symbol capture, shared tasks
	// ----------------------------------------
	initial
	begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	always @(posedge i_clock)
		if (o_sym_valid === 1'b1 && i_sym_ready === 1'b1)
			got.push_back(o_sym_data);
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic cfg(input logic en);
		@(posedge i_clock);
		i_baseband_enable <= en;
		i_cfg_write <= 1'b1;
		@(posedge i_clock);
		i_cfg_write <= 1'b0;
		repeat (3) @(posedge i_clock);
	endtask
	task automatic wait_run(input int n);
		for (int k = 0; k < n && o_running !== 1'b1; k++)
			@(posedge i_clock);
	endtask
	// bits are held back until the run starts, so the first bit is the pattern msb
	task automatic run(input logic bus, input int cyc);
		got.delete();
		hold <= 1'b1;
		cfg(1'b1);
		{i_bus_trigger, i_key_trigger} <= {bus, !bus};
		@(posedge i_clock);
		{i_bus_trigger, i_key_trigger} <= 2'h0;
		wait_run(20);
		hold <= 1'b0;
		repeat (cyc) @(posedge i_clock);
	endtask
	task automatic chk_syms(input logic [15:0] e);
		chk(got.size() >= 4, 1'b1);
		for (int i = 0; i < 4 && i < got.size(); i++)
			chk(got[i], e[15 - 4 * i -: 4]);
	endtask
	task automatic finish_test();
		$display("checked %0d, failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		#100000;
		failures++;
		finish_test();
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		{i_rst_b, i_cfg_write, i_baseband_enable, i_diff_encode_enable, i_phase_polarity,
			i_sample_clock_select, i_ext_trigger_polarity, i_ext_delay_enable, i_key_trigger,
			i_bus_trigger, i_ext_trigger, stall} = '0;
		{hold, pattern, i_ext_delay, i_msk_bias} = {1'b1, 16'hAAAA, 20'h00003, BSTC_BIAS_RST};
		i_symbol_rate = BSTC_RATE_RST;
		i_mod_type = BSTC_MOD_RST;
		i_trig_source = BSTC_SRC_RST;
		repeat (5) @(posedge i_clock);
		i_rst_b <= 1'b1;
		repeat (2) @(posedge i_clock);
		chk(o_symbol_rate, BSTC_RATE_RST);
		chk(o_msk_bias, BSTC_BIAS_RST);
		chk(o_bits_per_symbol, 3'h2);
		chk({o_baseband_on, o_q_invert, o_sample_clock_select, o_running}, 4'h0);
		$display("test reset done");
		for (int i = 0; i < 7; i++)
		begin
			i_mod_type <= mods[i];
			cfg(1'b0);
			chk(o_bits_per_symbol, bps[i]);
			chk(o_msk_bias_active, mods[i] == BSTC_MOD_MSK);
		end
		$display("test modulation map done");
		i_symbol_rate <= BSTC_RATE_MIN;
		cfg(1'b0);
		for (int i = 0; i < 4; i++)
		begin
			i_symbol_rate <= i == 0 ? BSTC_RATE_MIN - 32'h1
				: i == 1 ? BSTC_RATE_MAX + 32'h1 : BSTC_RATE_MAX;
			i_msk_bias <= i == 2 ? 7'h5B : 7'h00;
			i_trig_source <= i == 3 ? bstc_trig_src_e'(2'h3) : BSTC_TRIG_KEY;
			cfg(1'b0);
			chk({o_cfg_error, o_symbol_rate}, {1'b1, BSTC_RATE_MIN});
		end
		i_symbol_rate <= BSTC_RATE_MAX;
		i_trig_source <= BSTC_TRIG_KEY;
		{i_phase_polarity, i_sample_clock_select} <= 2'h3;
		cfg(1'b0);
		chk({o_cfg_error, o_q_invert, o_sample_clock_select}, 3'h3);
		chk({o_symbol_rate, o_msk_bias}, {BSTC_RATE_MAX, 7'h00});
		$display("test settings done");
		i_mod_type <= BSTC_MOD_BPSK;
		i_diff_encode_enable <= 1'b1;
		run(1'b0, 80);
		cfg(1'b0);
		chk_syms(16'h1111);
		i_diff_encode_enable <= 1'b0;
		i_trig_source <= BSTC_TRIG_BUS;
		run(1'b0, 20);
		chk(o_running, 1'b0);
		run(1'b1, 80);
		cfg(1'b0);
		chk_syms(16'h1010);
		i_mod_type <= BSTC_MOD_QPSK;
		pattern <= 16'hB4B4;
		run(1'b1, 80);
		cfg(1'b0);
		chk_syms(16'h2310);
		$display("test symbol stream done");
		i_trig_source <= BSTC_TRIG_EXT;
		{hold, i_ext_delay_enable} <= 2'h1;
		cfg(1'b1);
		wait_run(30);
		chk(o_running, 1'b0);
		i_ext_trigger_polarity <= 1'b1;
		cfg(1'b1);
		repeat (3) @(posedge i_clock);
		chk({o_delaying, o_running}, 2'h2);
		wait_run(100);
		chk(o_running, 1'b1);
		cfg(1'b0);
		i_ext_delay_enable <= 1'b0;
		cfg(1'b1);
		wait_run(5);
		chk({o_baseband_on, o_delaying, o_running}, 3'h5);
		cfg(1'b0);
		$display("test external trigger done");
		i_trig_source <= BSTC_TRIG_KEY;
		i_mod_type <= BSTC_MOD_BPSK;
		stall <= 1'b1;
		run(1'b0, 100);
		chk(o_overflow, 1'b1);
		{hold, stall} <= 2'h2;
		repeat (10) @(posedge i_clock);
		chk(got.size(), 5);
		cfg(1'b0);
		chk(o_overflow, 1'b0);
		$display("test buffer done");
		finish_test();
	end
endmodule
`default_nettype wire
